// [rtl/lin_uart_pkg.sv]
/*
 * Constants, register map and carrier types for the LIN-capable UART.
 * Assumes a 32-bit classic Wishbone slave port and a single clock domain.
 */
// Functional notes
// - Setting then clearing the break bit sends one break character, two if the break starts in the cycle the set takes effect.
// - Plain serial break lasts 10 bits, or 11 with long words; never doubled.
// - Breaks repeat back to back while the break bit stays set.
// - Toggling transmit enable queues an idle; a following break keeps correct length.
// - LIN enable set with short words and the slave bit clear selects LIN master mode.
// - A LIN master break lasts 13 bit times, never 24.
// - A queued idle character lasts exactly 10 bit times.
// - Receiver samples sixteen times per bit period.
// - Slave header over 57 bit times sets header error, interrupts, stays muted.
// - Time-out near the identifier stop bit never wakes the receiver.
// - On time-out header length loads zero and header detect stays clear.
// - Valid header clears wakeup bit and sets receive full after identifier stop.
// - Status access followed by data read clears the header error flag.
// - Software may set the wakeup bit to return the receiver to mute.
// - Outside mute every received byte with a mark stop bit raises a receive interrupt.
package lin_uart_pkg;
    // Register byte offsets
    localparam logic [7:0] SERIAL_CONTROL_OFS = 8'h00;
    localparam logic [7:0] BAUD_DIVIDER_OFS   = 8'h04;
    localparam logic [7:0] SERIAL_STATUS_OFS  = 8'h08;
    localparam logic [7:0] SERIAL_DATA_OFS    = 8'h0c;
    localparam logic [7:0] HEADER_LENGTH_OFS  = 8'h10;
    localparam logic [7:0] IRQ_STATUS_OFS     = 8'h14;
    localparam logic [7:0] IRQ_MASK_OFS       = 8'h18;

    // Control fields, low bits of the control register
    typedef struct packed {
        logic lin_slave;
        logic lin_en;
        logic word_len;
        logic break_request;
        logic tx_enable;
    } ctrl_t;
    localparam int          CTRL_W       = 5;
    localparam int          RWU_BIT      = 5;
    localparam ctrl_t       CTRL_RST     = 5'h00;
    localparam logic [15:0] BAUD_RST     = 16'h0033;

    // Interrupt status / mask bits
    typedef struct packed {
        logic brk_done;
        logic hdr_det;
        logic hdr_err;
        logic rx_full;
    } irq_t;
    localparam int IRQ_W = 4;

    // Character lengths in bit times
    localparam logic [4:0] IDLE_BITS     = 5'h0a;
    localparam logic [4:0] BRK_BITS_SHORT = 5'h0a;
    localparam logic [4:0] BRK_BITS_LONG  = 5'h0b;
    localparam logic [4:0] BRK_BITS_LIN   = 5'h0d;
    localparam logic [4:0] DATA_BITS     = 5'h0a;

    // Receiver oversampling
    localparam int         OVERSAMPLE = 16;
    localparam logic [3:0] SMP_LAST   = 4'hf;
    localparam logic [3:0] SMP_MID    = 4'h8;
    localparam logic [3:0] SMP_STOP   = 4'he;
    localparam logic [2:0] BYTE_LAST  = 3'h7;

    // LIN header
    localparam logic [7:0] SYNC_BYTE    = 8'h55;
    localparam int         HDR_MAX_BITS = 57;
    localparam logic [9:0] HDR_TMO_SMP  = 10'(HDR_MAX_BITS * OVERSAMPLE);
    localparam logic [9:0] HDR_BRK_SMP  = 10'(10 * OVERSAMPLE);
    localparam logic [7:0] HLR_TMO      = 8'h00;

    typedef enum logic [2:0] {
        TX_IDLE = 3'b000,
        TX_PRE  = 3'b001,
        TX_BRK  = 3'b010,
        TX_STOP = 3'b011,
        TX_DATA = 3'b100
    } tx_state_t;

    typedef enum logic [1:0] {
        RX_IDLE  = 2'b00,
        RX_START = 2'b01,
        RX_DATA  = 2'b10,
        RX_STOP  = 2'b11
    } rx_state_t;

    typedef enum logic [1:0] {
        HDR_NONE = 2'b00,
        HDR_SYNC = 2'b01,
        HDR_ID   = 2'b10
    } hdr_state_t;
endpackage : lin_uart_pkg

// [rtl/lin_uart.sv]
/*
 * LIN-capable UART: break and idle generation, byte transmit, 16x receiver,
 * LIN slave header detection with time-out and mute mode, interrupt logic.
 * Assumes a classic Wishbone master and a receive line synchronous to clk.
 */
// Design decisions made here: the Wishbone slave port and the register addresses.
`timescale 1ns/100ps
module lin_uart (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset_n,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Serial line
    input  wire logic        rxd,
    output logic             txd,
    // Interrupt
    output logic             irq
);
    lin_uart_pkg::ctrl_t      ctrl_r;
    lin_uart_pkg::irq_t       ist_r, imask_r, iset;
    lin_uart_pkg::tx_state_t  tx_st_r;
    lin_uart_pkg::rx_state_t  rx_st_r;
    lin_uart_pkg::hdr_state_t hdr_st_r;
    logic [15:0] baud_r, div_r;
    logic        smp_tick, bit_tick;
    logic [3:0]  tx_smp_r, rx_smp_r;
    logic [4:0]  tx_cnt_r, brk_len;
    logic [9:0]  tx_sh_r;
    logic [7:0]  tx_byte_r, rx_sh_r, rx_data_r, hlr_r;
    logic [2:0]  rx_idx_r;
    logic [9:0]  hdr_cnt_r;
    logic        txd_r, te_d_r, sbk_d_r, idle_pend_r, brk_pend_r, tx_pend_r;
    logic        rwu_r, rx_full_r, hdr_err_r, hdr_det_r, sr_seen_r, ack_r;
    logic        wr, rd, pre_start, brk_start, dat_start, brk_end;
    logic        fr_done, brk_det, hdr_tmo, hdr_ok, data_ok, mute, stop_r;
    logic        te_rise, sbk_rise, dat_rd, slave_mode, master_mode;

    function automatic logic hit(input logic [7:0] ofs);
        hit = (wb_adr_i == ofs);
    endfunction : hit

    // Bus decode; side effects happen at the acknowledging edge
    assign wr     = wb_cyc_i && wb_stb_i && !ack_r && wb_we_i;
    assign rd     = wb_cyc_i && wb_stb_i && !ack_r && !wb_we_i;
    assign dat_rd = rd && hit(lin_uart_pkg::SERIAL_DATA_OFS);
    assign wb_ack_o = ack_r;
    assign txd      = txd_r;
    assign irq      = |(ist_r & imask_r);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= wb_cyc_i && wb_stb_i && !ack_r;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (rd) begin
            if (hit(lin_uart_pkg::SERIAL_CONTROL_OFS)) begin
                wb_dat_o <= {26'h0, rwu_r, ctrl_r};
            end else if (hit(lin_uart_pkg::BAUD_DIVIDER_OFS)) begin
                wb_dat_o <= {16'h0, baud_r};
            end else if (hit(lin_uart_pkg::SERIAL_STATUS_OFS)) begin
                wb_dat_o <= {27'h0, tx_st_r != lin_uart_pkg::TX_IDLE,
                             rwu_r, hdr_det_r, hdr_err_r, rx_full_r};
            end else if (hit(lin_uart_pkg::SERIAL_DATA_OFS)) begin
                wb_dat_o <= {24'h0, rx_data_r};
            end else if (hit(lin_uart_pkg::HEADER_LENGTH_OFS)) begin
                wb_dat_o <= {24'h0, hlr_r};
            end else if (hit(lin_uart_pkg::IRQ_STATUS_OFS)) begin
                wb_dat_o <= {28'h0, ist_r};
            end else if (hit(lin_uart_pkg::IRQ_MASK_OFS)) begin
                wb_dat_o <= {28'h0, imask_r};
            end else begin
                wb_dat_o <= 32'h0000_0000;
            end
        end
    end

    // Control, divider and mask registers
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_r  <= lin_uart_pkg::CTRL_RST;
            baud_r  <= lin_uart_pkg::BAUD_RST;
            imask_r <= '0;
        end else if (wr) begin
            if (hit(lin_uart_pkg::SERIAL_CONTROL_OFS) && wb_sel_i[0]) begin
                ctrl_r <= lin_uart_pkg::ctrl_t'(wb_dat_i[lin_uart_pkg::CTRL_W-1:0]);
            end else if (hit(lin_uart_pkg::BAUD_DIVIDER_OFS)) begin
                if (wb_sel_i[0]) baud_r[7:0] <= wb_dat_i[7:0];
                if (wb_sel_i[1]) baud_r[15:8] <= wb_dat_i[15:8];
            end else if (hit(lin_uart_pkg::IRQ_MASK_OFS) && wb_sel_i[0]) begin
                imask_r <= wb_dat_i[lin_uart_pkg::IRQ_W-1:0];
            end
        end
    end

    assign master_mode = ctrl_r.lin_en && !ctrl_r.word_len && !ctrl_r.lin_slave;
    assign slave_mode  = ctrl_r.lin_en && ctrl_r.lin_slave;
    assign mute        = rwu_r;

    // Sample-rate divider, sixteen samples per bit
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            div_r <= 16'h0000;
        end else if (div_r == 16'h0000) begin
            div_r <= baud_r;
        end else begin
            div_r <= div_r - 16'h0001;
        end
    end
    assign smp_tick = (div_r == 16'h0000);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_smp_r <= 4'h0;
        end else if (smp_tick) begin
            tx_smp_r <= tx_smp_r + 4'h1;
        end
    end
    assign bit_tick = smp_tick && (tx_smp_r == lin_uart_pkg::SMP_LAST);

    // Transmit requests
    assign te_rise  = ctrl_r.tx_enable && !te_d_r;
    assign sbk_rise = ctrl_r.break_request && !sbk_d_r;
    always_comb begin
        brk_len = ctrl_r.word_len ? lin_uart_pkg::BRK_BITS_LONG
                                  : lin_uart_pkg::BRK_BITS_SHORT;
        if (master_mode) brk_len = lin_uart_pkg::BRK_BITS_LIN;
    end
    // Queued idle goes out first, then break, then data
    assign pre_start = bit_tick && tx_st_r == lin_uart_pkg::TX_IDLE && ctrl_r.tx_enable
                       && idle_pend_r;
    assign brk_start = bit_tick && tx_st_r == lin_uart_pkg::TX_IDLE && ctrl_r.tx_enable
                       && !idle_pend_r && (brk_pend_r || ctrl_r.break_request);
    assign dat_start = bit_tick && tx_st_r == lin_uart_pkg::TX_IDLE && ctrl_r.tx_enable
                       && !idle_pend_r && !brk_pend_r && !ctrl_r.break_request && tx_pend_r;
    assign brk_end   = bit_tick && tx_st_r == lin_uart_pkg::TX_STOP;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            te_d_r      <= 1'b0;
            sbk_d_r     <= 1'b0;
            idle_pend_r <= 1'b0;
            brk_pend_r  <= 1'b0;
        end else begin
            te_d_r  <= ctrl_r.tx_enable;
            sbk_d_r <= ctrl_r.break_request;
            if (te_rise) idle_pend_r <= 1'b1;
            else if (pre_start) idle_pend_r <= 1'b0;
            if (sbk_rise) brk_pend_r <= 1'b1;
            else if (brk_start) brk_pend_r <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_pend_r <= 1'b0;
            tx_byte_r <= 8'h00;
        end else if (wr && hit(lin_uart_pkg::SERIAL_DATA_OFS) && wb_sel_i[0]) begin
            tx_pend_r <= 1'b1;
            tx_byte_r <= wb_dat_i[7:0];
        end else if (dat_start) begin
            tx_pend_r <= 1'b0;
        end
    end

    // Transmit sequencer, one step per bit time
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_st_r  <= lin_uart_pkg::TX_IDLE;
            tx_cnt_r <= 5'h00;
            tx_sh_r  <= 10'h3ff;
            txd_r    <= 1'b1;
        end else if (bit_tick) begin
            case (tx_st_r)
                lin_uart_pkg::TX_IDLE: begin
                    txd_r <= 1'b1;
                    if (pre_start) begin
                        tx_st_r  <= lin_uart_pkg::TX_PRE;
                        tx_cnt_r <= lin_uart_pkg::IDLE_BITS - 5'h01;
                    end else if (brk_start) begin
                        tx_st_r  <= lin_uart_pkg::TX_BRK;
                        tx_cnt_r <= brk_len - 5'h01;
                        txd_r    <= 1'b0;
                    end else if (dat_start) begin
                        tx_st_r  <= lin_uart_pkg::TX_DATA;
                        tx_cnt_r <= lin_uart_pkg::DATA_BITS - 5'h01;
                        tx_sh_r  <= {1'b1, 1'b1, tx_byte_r};
                        txd_r    <= 1'b0;
                    end
                end
                lin_uart_pkg::TX_PRE: begin
                    txd_r    <= 1'b1;
                    tx_cnt_r <= tx_cnt_r - 5'h01;
                    if (tx_cnt_r == 5'h01) tx_st_r <= lin_uart_pkg::TX_IDLE;
                end
                lin_uart_pkg::TX_BRK: begin
                    tx_cnt_r <= tx_cnt_r - 5'h01;
                    if (tx_cnt_r == 5'h00) begin
                        tx_st_r <= lin_uart_pkg::TX_STOP;
                        txd_r   <= 1'b1;
                    end
                end
                lin_uart_pkg::TX_STOP: begin
                    tx_st_r <= lin_uart_pkg::TX_IDLE;
                end
                lin_uart_pkg::TX_DATA: begin
                    txd_r    <= tx_sh_r[0];
                    tx_sh_r  <= {1'b1, tx_sh_r[9:1]};
                    tx_cnt_r <= tx_cnt_r - 5'h01;
                    if (tx_cnt_r == 5'h01) tx_st_r <= lin_uart_pkg::TX_IDLE;
                end
                default: tx_st_r <= lin_uart_pkg::TX_IDLE;
            endcase
        end
    end

    // Receiver, sampling at the ninth of sixteen samples
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_st_r  <= lin_uart_pkg::RX_IDLE;
            rx_smp_r <= 4'h0;
            rx_idx_r <= 3'h0;
            rx_sh_r  <= 8'h00;
            stop_r   <= 1'b1;
        end else if (smp_tick) begin
            rx_smp_r <= rx_smp_r + 4'h1;
            case (rx_st_r)
                lin_uart_pkg::RX_IDLE: begin
                    rx_smp_r <= 4'h0;
                    if (!rxd) rx_st_r <= lin_uart_pkg::RX_START;
                end
                lin_uart_pkg::RX_START: begin
                    if (rx_smp_r == lin_uart_pkg::SMP_MID && rxd) begin
                        rx_st_r <= lin_uart_pkg::RX_IDLE;
                    end else if (rx_smp_r == lin_uart_pkg::SMP_LAST) begin
                        rx_st_r  <= lin_uart_pkg::RX_DATA;
                        rx_idx_r <= 3'h0;
                    end
                end
                lin_uart_pkg::RX_DATA: begin
                    if (rx_smp_r == lin_uart_pkg::SMP_MID) rx_sh_r <= {rxd, rx_sh_r[7:1]};
                    if (rx_smp_r == lin_uart_pkg::SMP_LAST) begin
                        rx_idx_r <= rx_idx_r + 3'h1;
                        if (rx_idx_r == lin_uart_pkg::BYTE_LAST) begin
                            rx_st_r <= lin_uart_pkg::RX_STOP;
                        end
                    end
                end
                lin_uart_pkg::RX_STOP: begin
                    if (rx_smp_r == lin_uart_pkg::SMP_MID) stop_r <= rxd;
                    if (rx_smp_r == lin_uart_pkg::SMP_STOP) rx_st_r <= lin_uart_pkg::RX_IDLE;
                end
                default: rx_st_r <= lin_uart_pkg::RX_IDLE;
            endcase
        end
    end

    // Frame completes at the fifteenth sample of the stop bit
    assign fr_done = smp_tick && rx_st_r == lin_uart_pkg::RX_STOP
                     && rx_smp_r == lin_uart_pkg::SMP_STOP;
    assign brk_det = fr_done && rx_sh_r == 8'h00 && !stop_r;
    assign hdr_tmo = smp_tick && hdr_st_r != lin_uart_pkg::HDR_NONE
                     && hdr_cnt_r >= lin_uart_pkg::HDR_TMO_SMP;
    // Time-out beats completion in the same sample
    assign hdr_ok  = fr_done && hdr_st_r == lin_uart_pkg::HDR_ID && stop_r && !hdr_tmo;
    assign data_ok = fr_done && stop_r && !mute;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            hdr_st_r  <= lin_uart_pkg::HDR_NONE;
            hdr_cnt_r <= 10'h000;
        end else if (hdr_tmo || hdr_ok) begin
            hdr_st_r <= lin_uart_pkg::HDR_NONE;
        end else if (brk_det && slave_mode && mute) begin
            hdr_st_r  <= lin_uart_pkg::HDR_SYNC;
            hdr_cnt_r <= lin_uart_pkg::HDR_BRK_SMP;
        end else begin
            if (smp_tick && hdr_st_r != lin_uart_pkg::HDR_NONE) begin
                hdr_cnt_r <= hdr_cnt_r + 10'h001;
            end
            if (fr_done && hdr_st_r == lin_uart_pkg::HDR_SYNC) begin
                hdr_st_r <= (rx_sh_r == lin_uart_pkg::SYNC_BYTE && stop_r)
                            ? lin_uart_pkg::HDR_ID : lin_uart_pkg::HDR_NONE;
            end
        end
    end

    // Mute bit: software sets or clears it, a valid header clears it
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rwu_r <= 1'b0;
        end else if (hdr_ok) begin
            rwu_r <= 1'b0;
        end else if (wr && hit(lin_uart_pkg::SERIAL_CONTROL_OFS) && wb_sel_i[0]) begin
            rwu_r <= wb_dat_i[lin_uart_pkg::RWU_BIT];
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            hlr_r <= 8'h00;
        end else if (hdr_tmo) begin
            hlr_r <= lin_uart_pkg::HLR_TMO;
        end else if (hdr_ok) begin
            hlr_r <= hdr_cnt_r[9:2];
        end
    end

    // Status flags; every set wins over a clear in the same cycle
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sr_seen_r <= 1'b0;
            rx_full_r <= 1'b0;
            hdr_err_r <= 1'b0;
            hdr_det_r <= 1'b0;
            rx_data_r <= 8'h00;
        end else begin
            if (rd && hit(lin_uart_pkg::SERIAL_STATUS_OFS)) sr_seen_r <= 1'b1;
            else if (dat_rd) sr_seen_r <= 1'b0;
            if (hdr_ok || data_ok) begin
                rx_full_r <= 1'b1;
                rx_data_r <= rx_sh_r;
            end else if (dat_rd) begin
                rx_full_r <= 1'b0;
            end
            if (hdr_tmo) hdr_err_r <= 1'b1;
            else if (dat_rd && sr_seen_r) hdr_err_r <= 1'b0;
            if (hdr_ok) hdr_det_r <= 1'b1;
            else if (dat_rd && sr_seen_r) hdr_det_r <= 1'b0;
        end
    end

    // Sticky interrupt status, write one to clear
    always_comb begin
        iset          = '0;
        iset.rx_full  = hdr_ok || data_ok;
        iset.hdr_err  = hdr_tmo;
        iset.hdr_det  = hdr_ok;
        iset.brk_done = brk_end;
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ist_r <= '0;
        end else if (wr && hit(lin_uart_pkg::IRQ_STATUS_OFS) && wb_sel_i[0]) begin
            ist_r <= (ist_r & ~wb_dat_i[lin_uart_pkg::IRQ_W-1:0]) | iset;
        end else begin
            ist_r <= ist_r | iset;
        end
    end

    // Helper counters for length checks
    logic [4:0] low_bits_r, pre_bits_r;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            low_bits_r <= 5'h00;
            pre_bits_r <= 5'h00;
        end else if (bit_tick) begin
            low_bits_r <= brk_start ? 5'h01
                        : (tx_st_r == lin_uart_pkg::TX_BRK) ? low_bits_r + 5'h01 : 5'h00;
            pre_bits_r <= pre_start ? 5'h01
                        : (tx_st_r == lin_uart_pkg::TX_PRE) ? pre_bits_r + 5'h01 : 5'h00;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence brk_leave_s;
        bit_tick && tx_st_r == lin_uart_pkg::TX_BRK && tx_cnt_r == 5'h00;
    endsequence
    sequence pre_leave_s;
        bit_tick && tx_st_r == lin_uart_pkg::TX_PRE && tx_cnt_r == 5'h01;
    endsequence

    brk_length_a: assert property (brk_leave_s |-> low_bits_r == brk_len)
        else $error("Break length differs from selected length");
    lin_break_a: assert property (brk_leave_s |-> !master_mode || low_bits_r == 5'h0d)
        else $error("LIN master break is not 13 bits");
    brk_stop_a: assert property (brk_leave_s |=> txd_r && tx_st_r == lin_uart_pkg::TX_STOP)
        else $error("No mark stop bit after break");
    pre_length_a: assert property (pre_leave_s |=> pre_bits_r == 5'h0a)
        else $error("Idle preamble not 10 bits");
    one_break_a: assert property (brk_start && !sbk_rise |=> !brk_pend_r)
        else $error("Break request still pending after break start");
    idle_first_a: assert property (te_rise |=> idle_pend_r)
        else $error("Enable toggle did not queue idle");
    tmo_mute_a: assert property (hdr_tmo |=> hdr_err_r && hlr_r == 8'h00 && !$rose(hdr_det_r)
                                 && $stable(rwu_r) && ist_r.hdr_err)
        else $error("Header time-out handled wrongly");
    wake_a: assert property (hdr_ok |=> !rwu_r && rx_full_r && hdr_det_r)
        else $error("Valid header did not wake receiver");
    mute_quiet_a: assert property (fr_done && rwu_r && !hdr_ok |=> !$rose(rx_full_r))
        else $error("Data flagged while muted");
    err_clear_a: assert property (dat_rd && sr_seen_r && !hdr_tmo |=> !hdr_err_r)
        else $error("Header error not cleared by status then data read");
endmodule : lin_uart

// [dv/lin_node.sv]
/* Remote serial node: sends frames on rxd and times low runs on txd.
   Assumes 16 clocks per bit time. */
`timescale 1ns/100ps
module lin_node (
    // Clock and line
    input  wire logic clk,
    input  wire logic txd,
    output logic      rxd
);
    initial rxd = 1'b1;
    // Start, eight bits LSB first, then the given stop level
    task automatic send(input logic [7:0] b, input logic stop_lvl);
        logic [9:0] f;
        f = {stop_lvl, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rxd <= f[i];
            repeat (16) @(posedge clk);
        end
        rxd <= 1'b1;
    endtask : send
    // Clocks of the next low run on txd, 0 if none within lim
    task automatic low_len(input int lim, output int n);
        int w;
        n = 0;
        w = 0;
        while (txd !== 1'b0 && w < lim) begin
            @(posedge clk);
            w++;
        end
        while (txd === 1'b0 && n < lim) begin
            @(posedge clk);
            n++;
        end
    endtask : low_len
endmodule : lin_node

// [dv/tb_lin_uart.sv]
/* Bench for lin_uart: break lengths, header wake and time-out, random bytes.
   Assumes lin_node as the far node and a baud divider of 0. */
`timescale 1ns/100ps
module tb_lin_uart;
    logic        clk = 0, reset_n = 0, cyc = 0, stb = 0, we = 0, ack, rxd, txd, irq;
    logic [7:0]  adr = 0, b;
    logic [3:0]  sel = 0;
    logic [31:0] wdat = 0, rdat, q;
    int          mismatches = 0, checks = 0, n;
    logic [4:0]  cfg [3] = '{5'h01, 5'h05, 5'h09};

    lin_uart dut_u (.clk(clk), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .rxd(rxd), .txd(txd), .irq(irq));
    lin_node node_u (.clk(clk), .txd(txd), .rxd(rxd));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'hf;
        wdat <= d;
        do begin
            @(posedge clk);
            k++;
        end while (ack !== 1'b1 && k < 50);
        if (ack !== 1'b1) begin
            mismatches++;
            tally_and_finish();
        end
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask : wb
    function automatic int brk_clks(input logic [4:0] c);
        return 16 * ((c[3] && !c[2]) ? 13 : (c[2] ? 11 : 10));
    endfunction : brk_clks
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        forever #5 clk = ~clk;
    end
    initial begin
        #200_000;
        mismatches++;
        tally_and_finish();
    end
    initial begin
        void'($urandom(73));
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        wb(1, 8'h04, 32'h0);
        wb(1, 8'h18, 32'hf);
        for (int m = 0; m < 3; m++) begin
            wb(1, 8'h00, {27'h0, cfg[m]} & 32'h1e);
            wb(1, 8'h00, {27'h0, cfg[m]});
            wb(1, 8'h00, {27'h0, cfg[m]} | 32'h2);
            wb(1, 8'h00, {27'h0, cfg[m]});
            node_u.low_len(4000, n);
            chk(n, brk_clks(cfg[m]));
            node_u.low_len(600, n);
            chk(n, 0);
        end
        wb(1, 8'h00, 32'h3);
        node_u.low_len(4000, n);
        chk(n, 160);
        node_u.low_len(200, n);
        chk(n, 160);
        wb(1, 8'h00, 32'h1);
        repeat (600) @(posedge clk);
        // Valid header wakes the muted slave
        wb(1, 8'h14, 32'hf);
        wb(1, 8'h00, 32'h38);
        node_u.send(8'h00, 1'b0);
        node_u.send(8'h55, 1'b1);
        node_u.send(8'h2a, 1'b1);
        repeat (32) @(posedge clk);
        chk({31'h0, irq}, 1);
        wb(0, 8'h08, 0);
        chk(q & 32'h1f, 32'h05);
        wb(0, 8'h0c, 0);
        chk(q & 32'hff, 32'h2a);
        // Header times out inside the identifier stop bit
        wb(1, 8'h14, 32'hf);
        wb(1, 8'h00, 32'h38);
        node_u.send(8'h00, 1'b0);
        node_u.send(8'h55, 1'b1);
        repeat (436) @(posedge clk);
        node_u.send(8'h2a, 1'b1);
        repeat (32) @(posedge clk);
        chk({31'h0, irq}, 1);
        wb(0, 8'h08, 0);
        chk(q & 32'h1f, 32'h0a);
        wb(0, 8'h10, 0);
        chk(q, 0);
        wb(0, 8'h0c, 0);
        wb(0, 8'h08, 0);
        chk(q & 32'h1f, 32'h08);
        wb(1, 8'h14, 32'hf);
        node_u.send(8'h3c, 1'b1);
        repeat (32) @(posedge clk);
        chk({31'h0, irq}, 0);
        // Random bytes outside mute
        wb(1, 8'h00, 32'h0);
        repeat (4) begin
            b = 8'($urandom);
            wb(1, 8'h14, 32'hf);
            node_u.send(b, 1'b1);
            repeat (32) @(posedge clk);
            chk({31'h0, irq}, 1);
            wb(0, 8'h0c, 0);
            chk(q & 32'hff, {24'h0, b});
        end
        wb(1, 8'h18, 32'h0);
        chk({31'h0, irq}, 0);
        wb(1, 8'h14, 32'hf);
        wb(1, 8'h18, 32'hf);
        chk({31'h0, irq}, 0);
        tally_and_finish();
    end
endmodule : tb_lin_uart
